// >>> verilog/apw_pkg.sv
// Operation
// - Bits 7:3 stop host reset per GPIO group
// - Bit 2 picks upper pins reset source
// - Mouse wake combination from three select bits
// - Write 1 pulses chassis clear, self-clears
// - Bit 4 holds user last power state
// - First-stage delay 300 or 200 ms
// - Second-stage delay none, 32, 96, 250 ms
// - Retrigger drops power-good then raises it
// - Bit 7 enables third wake key set
// - Bit 6 enables second wake key set
// - OS wake key pulses power switch
// - Power-loss return pulses switch 0.5 s
// - Bit 3 picks watchdog reset source
// - Bit 0 picks hardware monitor reset source
// - Global enable gates wake event, reset 3e
// - Per-source wake flags, write 1 clears
// - Per-source enables share status bit order
// - Power-loss policy field selects power-on behaviour
package apw_pkg;

    // ----------------------------------------
    // Register indices (byte address = 4 * index)
    // ----------------------------------------
    localparam logic [7:0] APW_IDX_PLOSS   = 8'he4;
    localparam logic [7:0] APW_IDX_GPIO    = 8'he5;
    localparam logic [7:0] APW_IDX_PGOPT   = 8'he6;
    localparam logic [7:0] APW_IDX_KEYSET  = 8'he7;
    localparam logic [7:0] APW_IDX_GWAKE   = 8'hf2;
    localparam logic [7:0] APW_IDX_STS_A   = 8'hf3;
    localparam logic [7:0] APW_IDX_EN_A    = 8'hf6;

    // ----------------------------------------
    // Reset values
    // ----------------------------------------
    localparam logic [7:0] APW_RST_PLOSS   = 8'h00;
    localparam logic [7:0] APW_RST_GPIO    = 8'h00;
    localparam logic [7:0] APW_RST_PGOPT   = 8'h1c;
    localparam logic [7:0] APW_RST_KEYSET  = 8'h00;
    localparam logic [7:0] APW_RST_GWAKE   = 8'h3e;
    localparam logic [6:0] APW_RST_STS     = 7'h00;
    localparam logic [6:0] APW_RST_EN      = 7'h00;

    // ----------------------------------------
    // Field positions and masks
    // ----------------------------------------
    localparam logic [7:0] APW_GPIO_MASK   = 8'hfc;
    localparam logic [7:0] APW_PGOPT_MASK  = 8'h9e;
    localparam logic [7:0] APW_KEYSET_MASK = 8'hf9;
    localparam logic [7:0] APW_PLOSS_MASK  = 8'he0;
    localparam int APW_B_MOUSE_UP  = 7;
    localparam int APW_B_CHASSIS   = 5;
    localparam int APW_B_LAST_OFF  = 4;
    localparam int APW_B_STG1_FAST = 3;
    localparam int APW_B_STG2_HI   = 2;
    localparam int APW_B_STG2_LO   = 1;
    localparam int APW_B_TRIG      = 0;
    localparam int APW_B_KEYSET3   = 7;
    localparam int APW_B_KEYSET2   = 6;
    localparam int APW_B_OS_KEY    = 5;
    localparam int APW_B_LOSS_PULSE = 4;
    localparam int APW_B_WDT_PG    = 3;
    localparam int APW_B_HWM_HOST  = 0;
    localparam int APW_B_PLOSS_EN  = 7;
    localparam int APW_B_POLICY_HI = 6;
    localparam int APW_B_POLICY_LO = 5;
    localparam int APW_B_GWAKE_EN  = 0;

    // ----------------------------------------
    // Timing
    // ----------------------------------------
    localparam int APW_CLK_NS       = 40;
    localparam int APW_MS_NS        = 1000000;
    localparam int APW_TICK_CYCLES  = APW_MS_NS / APW_CLK_NS;
    localparam logic [8:0] APW_STG1_SLOW_MS = 9'd300;
    localparam logic [8:0] APW_STG1_FAST_MS = 9'd200;
    localparam logic [8:0] APW_STG2_A_MS    = 9'd32;
    localparam logic [8:0] APW_STG2_B_MS    = 9'd96;
    localparam logic [8:0] APW_STG2_C_MS    = 9'd250;
    localparam logic [8:0] APW_PULSE_MS     = 9'd500;
    localparam logic [8:0] APW_RETRIG_MS    = 9'd1;

    // ----------------------------------------
    // Types
    // ----------------------------------------
    typedef enum logic [2:0] {
        PG_OFF  = 3'b000,
        PG_STG1 = 3'b001,
        PG_STG2 = 3'b010,
        PG_ON   = 3'b011,
        PG_LOW  = 3'b100
    } apw_pg_t;

    typedef struct packed {
        logic [14:0] div;
        logic [8:0]  ms;
        logic        busy;
        logic        done;
    } apw_tmr_t;

    typedef struct packed {
        logic [7:0] ploss;
        logic [7:0] gpio;
        logic [7:0] pgopt;
        logic       trig;
        logic [7:0] keyset;
        logic [7:0] gwake;
        logic [6:0] sts;
        logic [6:0] en;
        logic [6:0] irq_prev;
        apw_pg_t    pg;
        logic       ps_low;
        logic       chassis_clr;
        logic       pme;
        logic [7:0] rdata;
    } apw_st_t;

endpackage : apw_pkg

// >>> verilog/apw_ms_timer.sv
`timescale 1ns/1ps
`default_nettype none
module apw_ms_timer
    import apw_pkg::*;
#(
    parameter int TICK_CYCLES = APW_TICK_CYCLES
)(
    // Clock and reset
    input  wire logic       i_clk,
    input  wire logic       i_resetn,
    // Control
    input  wire logic       i_start,
    input  wire logic [8:0] i_ms,
    // Status
    output logic            o_busy,
    output logic            o_done
);

    apw_tmr_t st_reg;
    apw_tmr_t st_next;

    // ----------------------------------------
    // Millisecond down counter
    // ----------------------------------------
    // A restart reloads even while busy, so a new request never waits
    always_comb
    begin
        st_next      = st_reg;
        st_next.done = 1'b0;
        if (i_start)
        begin
            st_next.div  = '0;
            st_next.ms   = i_ms;
            st_next.busy = 1'b1;
        end
        else if (st_reg.busy)
        begin
            if (st_reg.div == 15'(TICK_CYCLES - 1))
            begin
                st_next.div = '0;
                if (st_reg.ms <= 9'd1)
                begin
                    st_next.ms   = '0;
                    st_next.busy = 1'b0;
                    st_next.done = 1'b1;
                end
                else
                begin
                    st_next.ms = st_reg.ms - 9'd1;
                end
            end
            else
            begin
                st_next.div = st_reg.div + 15'd1;
            end
        end
    end

    // State register
    always_ff @(posedge i_clk or negedge i_resetn)
    begin
        if (!i_resetn)
        begin
            st_reg <= '0;
        end
        else
        begin
            st_reg <= st_next;
        end
    end

    assign o_busy = st_reg.busy;
    assign o_done = st_reg.done;

endmodule : apw_ms_timer
`default_nettype wire

// >>> verilog/apw_regs.sv
// Local design decision: the APB interface to the registers.
`timescale 1ns/1ps
`default_nettype none
module apw_regs
    import apw_pkg::*;
#(
    parameter int TICK_CYCLES = APW_TICK_CYCLES
)(
    // Clock and reset
    input  wire logic        i_clk,
    input  wire logic        i_resetn,
    // APB slave
    input  wire logic        i_psel,
    input  wire logic        i_penable,
    input  wire logic        i_pwrite,
    input  wire logic [11:0] i_paddr,
    input  wire logic [31:0] i_pwdata,
    output logic [31:0]      o_prdata,
    output logic             o_pready,
    output logic             o_pslverr,
    // Wake sources and power inputs
    input  wire logic [6:0]  i_src_irq,
    input  wire logic        i_power_good_first_stage,
    input  wire logic        i_power_loss_return,
    input  wire logic        i_prev_state_on,
    input  wire logic        i_os_wake_key,
    input  wire logic        i_kb_wake_enable,
    input  wire logic        i_mouse_right_key_sel,
    input  wire logic        i_mouse_extra_key_sel,
    // Power and wake outputs
    output logic             o_power_good_out,
    output logic             o_power_good_mid_stage,
    output logic             o_power_switch_out_n,
    output logic             o_wake_event,
    output logic             o_chassis_clear,
    // Configuration outputs
    output logic [4:0]       o_gpio_host_reset_block,
    output logic             o_gp_upper_resume_sel,
    output logic [2:0]       o_mouse_wake_combo_sel,
    output logic             o_key_set_three_enable,
    output logic             o_key_set_two_enable,
    output logic             o_watchdog_rst_pg_sel,
    output logic             o_hwmon_rst_host_sel,
    output logic             o_last_state_off
);

    apw_st_t st_reg;
    apw_st_t st_next;

    logic       pg_start;
    logic [8:0] pg_ms;
    logic       pg_done;
    logic       ps_start;
    logic       ps_done;
    logic       apb_wr;
    logic       apb_setup;
    logic [7:0] idx;
    logic       hit_any;
    logic [6:0] rise;
    logic [6:0] wmask;
    logic       policy_on;
    logic [1:0] stg2_sel;
    logic [8:0] stg1_ms;
    logic [8:0] stg2_ms;

    // ----------------------------------------
    // Delay timers
    // ----------------------------------------
    apw_ms_timer #(.TICK_CYCLES(TICK_CYCLES)) u_pg_tmr (
        .i_clk    (i_clk),
        .i_resetn (i_resetn),
        .i_start  (pg_start),
        .i_ms     (pg_ms),
        .o_busy   (),
        .o_done   (pg_done)
    );

    apw_ms_timer #(.TICK_CYCLES(TICK_CYCLES)) u_ps_tmr (
        .i_clk    (i_clk),
        .i_resetn (i_resetn),
        .i_start  (ps_start),
        .i_ms     (APW_PULSE_MS),
        .o_busy   (),
        .o_done   (ps_done)
    );

    // ----------------------------------------
    // Decode and helpers
    // ----------------------------------------
    // Word-aligned only; low two address bits must be zero
    assign idx       = i_paddr[9:2];
    assign hit_any   = (i_paddr[11:10] == 2'b00) && (i_paddr[1:0] == 2'b00)
                     && (idx == APW_IDX_PLOSS || idx == APW_IDX_GPIO
                     || idx == APW_IDX_PGOPT || idx == APW_IDX_KEYSET
                     || idx == APW_IDX_GWAKE || idx == APW_IDX_STS_A
                     || idx == APW_IDX_EN_A);
    assign apb_setup = i_psel && !i_penable;
    assign apb_wr    = i_psel && i_penable && i_pwrite && hit_any;
    assign rise      = i_src_irq & ~st_reg.irq_prev;
    assign wmask     = i_pwdata[6:0];
    assign stg2_sel  = {st_reg.pgopt[APW_B_STG2_HI], st_reg.pgopt[APW_B_STG2_LO]};

    // Delay choices
    assign stg1_ms = st_reg.pgopt[APW_B_STG1_FAST] ? APW_STG1_FAST_MS
                                                   : APW_STG1_SLOW_MS;
    always_comb
    begin
        unique case (stg2_sel)
            2'b00: stg2_ms = '0;
            2'b01: stg2_ms = APW_STG2_A_MS;
            2'b10: stg2_ms = APW_STG2_B_MS;
            2'b11: stg2_ms = APW_STG2_C_MS;
        endcase
    end

    // Power-on decision after power loss
    always_comb
    begin
        unique case ({st_reg.ploss[APW_B_POLICY_HI], st_reg.ploss[APW_B_POLICY_LO]})
            2'b00: policy_on = 1'b0;
            2'b01: policy_on = 1'b1;
            2'b10: policy_on = i_prev_state_on;
            2'b11: policy_on = !st_reg.pgopt[APW_B_LAST_OFF];
        endcase
    end

    // Power switch pulse requests
    assign ps_start = (i_power_loss_return && policy_on
                       && st_reg.keyset[APW_B_LOSS_PULSE])
                   || (i_os_wake_key && i_kb_wake_enable
                       && st_reg.keyset[APW_B_OS_KEY]);

    // ----------------------------------------
    // Next-state logic
    // ----------------------------------------
    always_comb
    begin
        st_next             = st_reg;
        st_next.chassis_clr = 1'b0;
        st_next.irq_prev    = i_src_irq;
        pg_start            = 1'b0;
        pg_ms               = stg1_ms;

        // Register writes take effect in the access phase
        if (apb_wr)
        begin
            unique case (idx)
                APW_IDX_PLOSS:  st_next.ploss  = i_pwdata[7:0] & APW_PLOSS_MASK;
                APW_IDX_GPIO:   st_next.gpio   = i_pwdata[7:0] & APW_GPIO_MASK;
                APW_IDX_KEYSET: st_next.keyset = i_pwdata[7:0] & APW_KEYSET_MASK;
                APW_IDX_GWAKE:  st_next.gwake  = i_pwdata[7:0];
                APW_IDX_EN_A:   st_next.en     = wmask;
                APW_IDX_PGOPT:
                begin
                    st_next.pgopt       = i_pwdata[7:0] & APW_PGOPT_MASK;
                    st_next.chassis_clr = i_pwdata[APW_B_CHASSIS];
                end
                default: st_next.sts = st_reg.sts & ~wmask;
            endcase
        end

        // Hardware set wins over a same-cycle clear
        st_next.sts = st_next.sts | rise;

        // Event output, masked per source then globally
        st_next.pme = st_reg.gwake[APW_B_GWAKE_EN] && |(st_reg.sts & st_reg.en);

        // Retrigger request stays pending until the sequencer takes it
        if (apb_wr && idx == APW_IDX_PGOPT && i_pwdata[APW_B_TRIG])
        begin
            st_next.trig = 1'b1;
        end

        // Power-good sequencer
        if (!i_power_good_first_stage)
        begin
            st_next.pg = PG_OFF;
        end
        else
        begin
            unique case (st_reg.pg)
                PG_OFF:
                begin
                    pg_start   = 1'b1;
                    st_next.pg = PG_STG1;
                end
                PG_STG1:
                begin
                    if (pg_done)
                    begin
                        if (stg2_ms == 9'd0)
                        begin
                            st_next.pg = PG_ON;
                        end
                        else
                        begin
                            pg_start   = 1'b1;
                            pg_ms      = stg2_ms;
                            st_next.pg = PG_STG2;
                        end
                    end
                end
                PG_STG2:
                begin
                    if (pg_done)
                    begin
                        st_next.pg = PG_ON;
                    end
                end
                PG_ON:
                begin
                    // Drop low for 1 ms, then rise again through stage two unless its delay is none
                    if (st_reg.trig)
                    begin
                        pg_start     = 1'b1;
                        pg_ms        = APW_RETRIG_MS;
                        st_next.pg   = PG_LOW;
                        st_next.trig = 1'b0;
                    end
                end
                PG_LOW:
                begin
                    if (pg_done)
                    begin
                        pg_start   = stg2_ms != 9'd0;
                        pg_ms      = stg2_ms;
                        st_next.pg = (stg2_ms == 9'd0) ? PG_ON : PG_STG2;
                    end
                end
                default: st_next.pg = PG_OFF;
            endcase
        end

        // Power switch low pulse
        if (ps_start)
        begin
            st_next.ps_low = 1'b1;
        end
        else if (ps_done)
        begin
            st_next.ps_low = 1'b0;
        end

        // Read data captured in the setup phase
        if (apb_setup)
        begin
            unique case (idx)
                APW_IDX_PLOSS:  st_next.rdata = st_reg.ploss;
                APW_IDX_GPIO:   st_next.rdata = st_reg.gpio;
                APW_IDX_PGOPT:  st_next.rdata = st_reg.pgopt
                                              | {7'h00, st_reg.trig};
                APW_IDX_KEYSET: st_next.rdata = st_reg.keyset;
                APW_IDX_GWAKE:  st_next.rdata = st_reg.gwake;
                APW_IDX_STS_A:  st_next.rdata = {1'b0, st_reg.sts};
                APW_IDX_EN_A:   st_next.rdata = {1'b0, st_reg.en};
                default:        st_next.rdata = 8'h00;
            endcase
        end
    end

    // ----------------------------------------
    // State register
    // ----------------------------------------
    always_ff @(posedge i_clk or negedge i_resetn)
    begin
        if (!i_resetn)
        begin
            st_reg.ploss       <= APW_RST_PLOSS;
            st_reg.gpio        <= APW_RST_GPIO;
            st_reg.pgopt       <= APW_RST_PGOPT;
            st_reg.trig        <= 1'b0;
            st_reg.keyset      <= APW_RST_KEYSET;
            st_reg.gwake       <= APW_RST_GWAKE;
            st_reg.sts         <= APW_RST_STS;
            st_reg.en          <= APW_RST_EN;
            st_reg.irq_prev    <= 7'h00;
            st_reg.pg          <= PG_OFF;
            st_reg.ps_low      <= 1'b0;
            st_reg.chassis_clr <= 1'b0;
            st_reg.pme         <= 1'b0;
            st_reg.rdata       <= 8'h00;
        end
        else
        begin
            st_reg <= st_next;
        end
    end

    // ----------------------------------------
    // Outputs
    // ----------------------------------------
    // Zero wait states keep the bus simple; reads see setup-phase state
    assign o_pready  = 1'b1;
    assign o_pslverr = i_psel && i_penable && !hit_any;
    assign o_prdata  = {24'h000000, st_reg.rdata};

    assign o_power_good_out       = st_reg.pg == PG_ON;
    assign o_power_good_mid_stage = st_reg.pg != PG_OFF && st_reg.pg != PG_STG1;
    assign o_power_switch_out_n   = !st_reg.ps_low;
    assign o_wake_event           = st_reg.pme;
    assign o_chassis_clear        = st_reg.chassis_clr;
    assign o_gpio_host_reset_block = st_reg.gpio[7:3];
    assign o_gp_upper_resume_sel  = st_reg.gpio[2];
    assign o_mouse_wake_combo_sel = {st_reg.pgopt[APW_B_MOUSE_UP],
                                     i_mouse_right_key_sel,
                                     i_mouse_extra_key_sel};
    assign o_key_set_three_enable = st_reg.keyset[APW_B_KEYSET3];
    assign o_key_set_two_enable   = st_reg.keyset[APW_B_KEYSET2];
    assign o_watchdog_rst_pg_sel  = st_reg.keyset[APW_B_WDT_PG];
    assign o_hwmon_rst_host_sel   = st_reg.keyset[APW_B_HWM_HOST];
    assign o_last_state_off       = st_reg.pgopt[APW_B_LAST_OFF];

    // ----------------------------------------
    // Assertions
    // ----------------------------------------
    default clocking cb @(posedge i_clk); endclocking
    default disable iff (!i_resetn);

    logic    gen;
    apw_pg_t pg_q;
    assign gen  = st_reg.gwake[APW_B_GWAKE_EN];
    assign pg_q = st_reg.pg;

    sequence s_stage_two_exit;
        pg_q == PG_STG2 && pg_done;
    endsequence

    sequence s_stage_one_bypass;
        pg_q == PG_STG1 && pg_done && stg2_sel == 2'b00;
    endsequence

    a_pme_global_gate: assert property (!gen |=> !o_wake_event)
        else $error("wake event while globally disabled");
    a_sts_sets_rise: assert property ((rise != 7'h00)
        |=> ((st_reg.sts & $past(rise)) == $past(rise)))
        else $error("status flag missed an irq rise");
    a_sts_w1c: assert property ((apb_wr && idx == APW_IDX_STS_A && rise == 7'h00)
        |=> ((st_reg.sts & $past(wmask)) == 7'h00))
        else $error("status not cleared by write one");
    a_pme_enabled: assert property ((gen && |(st_reg.sts & st_reg.en))
        |=> o_wake_event)
        else $error("enabled flag failed to raise event");
    a_chassis_pulse: assert property (o_chassis_clear |=> !o_chassis_clear)
        else $error("chassis clear longer than one cycle");
    a_retrig_drop: assert property ((pg_q == PG_ON && st_reg.trig && i_power_good_first_stage)
        |=> !o_power_good_out ##1 !st_reg.trig || $past(apb_wr))
        else $error("retrigger did not drop power-good");
    a_pg_order: assert property ((s_stage_two_exit or s_stage_one_bypass)
        and i_power_good_first_stage |=> o_power_good_out)
        else $error("power-good not released after delays");
    a_pg_loss: assert property (!i_power_good_first_stage |=> !o_power_good_out)
        else $error("power-good high without first stage");
    a_power_switch_out_n_start: assert property (ps_start |=> !o_power_switch_out_n)
        else $error("power switch pulse not started");
    a_apb_unmapped: assert property ((i_psel && i_penable && !hit_any)
        |-> o_pslverr && o_pready)
        else $error("unmapped access not flagged");

endmodule : apw_regs
`default_nettype wire

// >>> dv/apw_host_model.sv
`timescale 1ns/1ps
`default_nettype none
module apw_host_model (
    // Clock and commands
    input  wire logic       i_clk,
    input  wire logic       i_pwr_on,
    input  wire logic [6:0] i_irq_set,
    input  wire logic       i_loss_req,
    // Toward the block
    output logic            o_first_stage,
    output logic [6:0]      o_irq,
    output logic            o_loss
);
    // Chipset levels follow commands one cycle late; unknown only before the first edge, inside reset
    always @(posedge i_clk)
    begin
        o_first_stage <= i_pwr_on;
        o_irq         <= i_irq_set;
        o_loss        <= i_loss_req;
    end
endmodule : apw_host_model
`default_nettype wire

// >>> dv/acpi_power_wake_config_regs_test.sv
`timescale 1ns/1ps
`default_nettype none
module acpi_power_wake_config_regs_test;
    import apw_pkg::*;
    // ------
    // Signals
    // ------
    localparam int TICK = 4;
    localparam logic [7:0] IDX [5] = '{8'he5, 8'he6, 8'he7, 8'hf2, 8'hf3};
    localparam logic [7:0] RST [5] = '{8'h00, 8'h1c, 8'h00, 8'h3e, 8'h00};
    logic        clk = 0, resetn = 0, psel = 0, penable = 0, pwrite = 0, er, chseen = 0;
    logic        pwr_on = 0, loss_req = 0, os_key = 0, kb_en = 0, prev_on = 0, m_r = 0, m_x = 0;
    logic [11:0] paddr = '0;
    logic [31:0] pwdata = '0, prdata, rd;
    logic [6:0]  irq_set = '0, irq;
    logic [7:0]  v, e;
    logic        pready, pslverr, first, loss, pg, mid, sw_n, wake, chclr, gp_up, k3, k2, wdt, hwm, lso;
    logic [4:0]  gblk;
    logic [2:0]  combo;
    int          failures = 0, comparisons = 0, seed = 76, n;

    always #20 clk = ~clk;
    // Clear pulse is one cycle wide, so latch it
    always @(posedge clk) if (chclr === 1'b1) chseen <= 1'b1;

    apw_host_model u_apw_host_model (.i_clk(clk), .i_pwr_on(pwr_on), .i_irq_set(irq_set), .i_loss_req(loss_req),
        .o_first_stage(first), .o_irq(irq), .o_loss(loss));
    apw_regs #(.TICK_CYCLES(TICK)) u_apw_regs (.i_clk(clk), .i_resetn(resetn), .i_psel(psel),
        .i_penable(penable), .i_pwrite(pwrite), .i_paddr(paddr), .i_pwdata(pwdata), .o_prdata(prdata),
        .o_pready(pready), .o_pslverr(pslverr), .i_src_irq(irq), .i_power_good_first_stage(first),
        .i_power_loss_return(loss), .i_prev_state_on(prev_on), .i_os_wake_key(os_key),
        .i_kb_wake_enable(kb_en), .i_mouse_right_key_sel(m_r), .i_mouse_extra_key_sel(m_x),
        .o_power_good_out(pg), .o_power_good_mid_stage(mid), .o_power_switch_out_n(sw_n),
        .o_wake_event(wake), .o_chassis_clear(chclr), .o_gpio_host_reset_block(gblk),
        .o_gp_upper_resume_sel(gp_up), .o_mouse_wake_combo_sel(combo), .o_key_set_three_enable(k3),
        .o_key_set_two_enable(k2), .o_watchdog_rst_pg_sel(wdt), .o_hwmon_rst_host_sel(hwm),
        .o_last_state_off(lso));

    // ------
    // Tasks
    // ------
    task automatic end_sim();
        if (failures == 0 && comparisons > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask : end_sim

    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        comparisons++;
        if (got !== exp)
        begin
            failures++;
            $display("MISMATCH %s expected %h seen %h", what, exp, got);
        end
    endtask : chk

    // Bounded wait; n returns the cycles spent
    task automatic wait_for(ref logic s, input logic lvl, input int lim);
        n = 0;
        while (s !== lvl && n < lim)
        begin
            @(posedge clk);
            n++;
        end
        if (s !== lvl)
        begin
            failures++;
            end_sim();
        end
    endtask : wait_for

    // One APB transfer; request held until pready is seen high
    task automatic apb(input logic w, input logic [7:0] idx, input logic [7:0] wd);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= {2'b00, idx, 2'b00};
        pwdata <= {24'h0, wd};
        @(posedge clk);
        penable <= 1'b1;
        @(posedge clk);
        wait_for(pready, 1'b1, 20);
        rd = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge clk);
    endtask : apb

    task automatic fire(input logic os, input logic exp);
        loss_req <= ~os;
        os_key <= os;
        @(posedge clk);
        loss_req <= 1'b0;
        os_key <= 1'b0;
        repeat (6) @(posedge clk);
        chk("switch low", {31'h0, exp}, {31'h0, ~sw_n});
        if (exp)
        begin
            wait_for(sw_n, 1'b1, 2100);
            chk("pulse len", 1, 32'(n >= 499 * TICK && n <= 500 * TICK));
        end
    endtask : fire

    function automatic int pg_delay(input logic [7:0] o);
        int s2;
        s2 = o[2:1] == 2'b00 ? 0 : o[2:1] == 2'b01 ? 32 : o[2:1] == 2'b10 ? 96 : 250;
        return ((o[3] ? 200 : 300) + s2) * TICK;
    endfunction : pg_delay

    // ------
    // Sequence
    // ------
    initial
    begin
        repeat (20) @(posedge clk);
        resetn <= 1'b1;
        @(posedge clk);
        for (int i = 0; i < 5; i++)
        begin
            apb(1'b0, IDX[i], 8'h00);
            chk("reset value", {24'h0, RST[i]}, rd);
        end
        apb(1'b0, 8'he8, 8'h00);
        chk("unmapped", 32'h1, {rd[30:0], er});
        for (int i = 0; i < 8; i++)
        begin
            v = 8'($random(seed));
            apb(1'b1, 8'he5, v);
            apb(1'b1, 8'he7, v);
            apb(1'b0, 8'he5, 8'h00);
            chk("e5", {24'h0, v & 8'hfc}, rd);
            apb(1'b0, 8'he7, 8'h00);
            chk("e7", {24'h0, v & 8'hf9}, rd);
            chk("group block", 32'(v[7:3]), 32'(gblk));
            chk("cfg", 32'({v[2], v[7:6], v[3], v[0]}), 32'({gp_up, k3, k2, wdt, hwm}));
        end
        for (int c = 0; c < 4; c++)
        begin
            v = (8'($random(seed)) & 8'h98) | 8'(c << 1);
            pwr_on <= 1'b0;
            m_r <= c[0];
            m_x <= c[1];
            apb(1'b1, 8'he6, v);
            apb(1'b0, 8'he6, 8'h00);
            chk("e6", {24'h0, v}, rd);
            chk("mouse combo", 32'({v[7], c[0], c[1]}), 32'(combo));
            chk("last off", 32'(v[4]), 32'(lso));
            chk("pg off", 0, 32'(pg));
            chk("mid off", 0, 32'(mid));
            pwr_on <= 1'b1;
            wait_for(first, 1'b1, 5);
            wait_for(pg, 1'b1, 2400);
            chk("pg delay", 1, 32'(n >= pg_delay(v) && n <= pg_delay(v) + 4));
            chk("mid on", 1, 32'(mid));
        end
        apb(1'b1, 8'he6, v | 8'h01);
        wait_for(pg, 1'b0, 4);
        chk("mid held", 1, 32'(mid));
        wait_for(pg, 1'b1, 260 * TICK);
        chk("retrig stage two", 1, 32'(n >= 250 * TICK));
        apb(1'b1, 8'he6, 8'h20);
        apb(1'b0, 8'he6, 8'h00);
        chk("chassis", 32'h1, {rd[31:1], chseen});
        e = 8'(1 << ($unsigned($random(seed)) % 7));
        apb(1'b1, 8'hf6, e);
        irq_set <= 7'h7f;
        repeat (4) @(posedge clk);
        chk("gated", 0, 32'(wake));
        apb(1'b0, 8'hf3, 8'h00);
        chk("status", 32'h7f, rd);
        apb(1'b1, 8'hf2, 8'h3f);
        wait_for(wake, 1'b1, 6);
        apb(1'b1, 8'hf3, ~e);
        apb(1'b0, 8'hf3, 8'h00);
        chk("status left", {24'h0, e}, rd);
        chk("event held", 1, 32'(wake));
        apb(1'b1, 8'hf3, e);
        wait_for(wake, 1'b0, 6);
        apb(1'b1, 8'he7, 8'h30);
        for (int p = 0; p < 4; p++)
        begin
            prev_on <= 1'($random(seed));
            apb(1'b1, 8'he4, 8'(8'h80 | (p << 5)));
            fire(1'b0, p == 1 || (p == 2 && prev_on) || p == 3);
        end
        kb_en <= 1'b1;
        fire(1'b1, 1'b1);
        end_sim();
    end

    initial
    begin
        repeat (100000) @(posedge clk);
        failures++;
        end_sim();
    end
endmodule : acpi_power_wake_config_regs_test
`default_nettype wire
